// file: verilog/fbc_pkg.sv
package fbc_pkg;
	localparam int          TAP_COUNT    = 5;
	localparam int          SIDE_W       = 12;
	localparam int          CENTER_W     = 18;
	localparam int          SIDE_REG_W   = 16;
	localparam int          CENTER_REG_W = 24;
	localparam int          ADDR_W       = 12;
	localparam int          DATA_W       = 32;
	localparam logic [11:0] TAP1_OFS     = 12'h448;
	localparam logic [11:0] TAP2_OFS     = 12'h44A;
	localparam logic [11:0] TAP3_OFS     = 12'h44C;
	localparam logic [11:0] TAP4_OFS     = 12'h44E;
	localparam logic [11:0] CENTER_OFS   = 12'h450;
	localparam logic [11:0] MODE_OFS     = 12'h460;
	localparam logic [23:0] COEFF_RESET  = 24'h000000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;
	localparam int          CENTER_IDX   = 4;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] word;
		logic [31:0] wdata;
	} fbc_req_t;
endpackage : fbc_pkg

// file: verilog/fbc_bus_if.sv
`timescale 1ns/1ps
interface fbc_bus_if;
	logic                  wr;
	logic                  rd;
	logic [11:0]           word;
	logic [31:0]           wdata;
	logic [4:0]            hit;
	logic                  mode_hit;
	modport dec (input wr, rd, word, output hit, mode_hit);
	modport top (output wr, rd, word, wdata, input hit, mode_hit);
endinterface : fbc_bus_if

// file: verilog/fbc_addr_dec.sv
`timescale 1ns/1ps
module fbc_addr_dec (
	fbc_bus_if.dec bus
);
	// one-hot select per tap register, offset compared as word index
	always_comb begin
		bus.hit[0]   = (bus.word == fbc_pkg::TAP1_OFS);
		bus.hit[1]   = (bus.word == fbc_pkg::TAP2_OFS);
		bus.hit[2]   = (bus.word == fbc_pkg::TAP3_OFS);
		bus.hit[3]   = (bus.word == fbc_pkg::TAP4_OFS);
		bus.hit[4]   = (bus.word == fbc_pkg::CENTER_OFS);
		bus.mode_hit = (bus.word == fbc_pkg::MODE_OFS);
	end
endmodule : fbc_addr_dec

// file: verilog/fbc_coeff_regs.sv
`timescale 1ns/1ps
module fbc_coeff_regs #(
	// bank shape; only the documented layout is served
	parameter int TAP_NUM   = fbc_pkg::TAP_COUNT,
	parameter int SIDE_BITS = fbc_pkg::SIDE_W,
	parameter int CENT_BITS = fbc_pkg::CENTER_W,
	parameter int SIDE_REG  = fbc_pkg::SIDE_REG_W,
	parameter int CENT_REG  = fbc_pkg::CENTER_REG_W,
	parameter int ADDR_BITS = fbc_pkg::ADDR_W,
	parameter int DATA_BITS = fbc_pkg::DATA_W
) (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// avalon-mm slave, word address = register index
	input  wire logic [11:0] AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// filter datapath side
	output logic signed [11:0] CHAN_B_TAP1_VALUE,
	output logic signed [11:0] CHAN_B_TAP2_VALUE,
	output logic signed [11:0] CHAN_B_TAP3_VALUE,
	output logic signed [11:0] CHAN_B_TAP4_VALUE,
	output logic signed [17:0] CHAN_B_CENTER_VALUE,
	output logic             CHAN_B_FILTER_ACTIVE,
	output logic             DUAL_CHANNEL_MODE
);
	////////////////////////////////////////////////////////////////////////
	// elaboration checks: ports and fields fixed to this layout

	if (TAP_NUM != fbc_pkg::TAP_COUNT) begin : g_chk_taps
		$error("tap count must be five");
	end

	if (SIDE_BITS != fbc_pkg::SIDE_W) begin : g_chk_side
		$error("outer tap field must be twelve bits");
	end

	if (CENT_BITS != fbc_pkg::CENTER_W) begin : g_chk_cent
		$error("centre tap field must be eighteen bits");
	end

	if (SIDE_REG != fbc_pkg::SIDE_REG_W) begin : g_chk_side_reg
		$error("outer tap register must be sixteen bits");
	end

	if (CENT_REG != fbc_pkg::CENTER_REG_W) begin : g_chk_cent_reg
		$error("centre tap register must be twenty-four bits");
	end

	if (ADDR_BITS != fbc_pkg::ADDR_W) begin : g_chk_addr
		$error("address must be twelve bits");
	end

	if (DATA_BITS != fbc_pkg::DATA_W) begin : g_chk_data
		$error("data bus must be thirty-two bits");
	end

	if (fbc_pkg::CENTER_IDX >= TAP_NUM) begin : g_chk_idx
		$error("centre index must lie inside the bank");
	end

	if (fbc_pkg::CENTER_OFS <= fbc_pkg::TAP1_OFS) begin : g_chk_ofs
		$error("centre register must follow the outer taps");
	end

	if (fbc_pkg::COEFF_RESET != '0) begin : g_chk_rst
		$error("coefficient reset value must be zero");
	end

	////////////////////////////////////////////////////////////////////////
	// access phase and registered state

	// access phase: idle or answering
	typedef enum logic [0:0] {
		FBC_IDLE   = 1'b0,
		FBC_ANSWER = 1'b1
	} fbc_phase_t;

	// whole state of the bank
	typedef struct packed {
		// stored register images
		logic [4:0][23:0] coeff;
		logic             dual;
		// bus answer
		fbc_phase_t       phase;
		logic             waitreq;
		logic [31:0]      rdata;
		// copies facing the filter
		logic [3:0][11:0] side_out;
		logic [17:0]      center_out;
		logic             active;
		logic             mode_out;
	} fbc_state_t;

	fbc_state_t s_q;
	fbc_state_t s_d;
	fbc_bus_if  bus ();

	////////////////////////////////////////////////////////////////////////
	// address decode

	assign bus.wr    = AVS_WRITE;
	assign bus.rd    = AVS_READ;
	assign bus.word  = AVS_ADDRESS;
	assign bus.wdata = AVS_WRITEDATA;

	fbc_addr_dec u_dec (
		.bus (bus)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// any bus request, read or write
	function automatic logic is_request(
		input logic rd,
		input logic wr
	);
		return rd || wr;
	endfunction : is_request

	// coefficient bits of an outer tap
	function automatic logic [11:0] side_field(
		input logic [23:0] c
	);
		return c[fbc_pkg::SIDE_W-1:0];
	endfunction : side_field

	// coefficient bits of the centre tap
	function automatic logic [17:0] center_field(
		input logic [23:0] c
	);
		return c[fbc_pkg::CENTER_W-1:0];
	endfunction : center_field

	// upper byte of the bus always reads zero
	function automatic logic [31:0] read_word(
		input logic [23:0] c
	);
		return {8'h00, c};
	endfunction : read_word

	// mode word reads back in bit zero only
	function automatic logic [31:0] mode_word(
		input logic dual
	);
		return {31'h00000000, dual};
	endfunction : mode_word

	// mode bit changes only when its byte lane is enabled
	function automatic logic next_mode(
		input logic        old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic m;
		m = old;
		if (be[0]) begin
			m = wd[0];
		end
		return m;
	endfunction : next_mode

	// writable bits of one register, reserved bits included
	function automatic logic [23:0] reg_mask(
		input logic center
	);
		logic [23:0] m;
		m = 24'({fbc_pkg::SIDE_REG_W{1'b1}});
		if (center) begin
			m = {fbc_pkg::CENTER_REG_W{1'b1}};
		end
		return m;
	endfunction : reg_mask

	// byte-enable merge, limited to register width
	function automatic logic [23:0] merge(
		input logic [23:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be,
		input logic        center
	);
		logic [23:0] r;
		r = old;
		for (int b = 0; b < fbc_pkg::CENTER_REG_W / 8; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r & reg_mask(center);
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic       take;
		logic [4:0] wr_sel;
		logic [4:0] rd_sel;

		// hold everything unless changed below
		s_d    = s_q;
		take   = (s_q.phase == FBC_IDLE) && is_request(AVS_READ, AVS_WRITE);
		// write strobe, and readdata select on any access (read or write), one bit per tap register
		wr_sel = bus.hit & {fbc_pkg::TAP_COUNT{take && AVS_WRITE}};
		rd_sel = bus.hit & {fbc_pkg::TAP_COUNT{take}};

		// one answer cycle per access, then back to idle
		case (s_q.phase)
			FBC_IDLE: begin
				// take a request
				if (take) begin
					s_d.phase = FBC_ANSWER;
				end
			end
			FBC_ANSWER: begin
				// waitrequest low this cycle
				s_d.phase = FBC_IDLE;
			end
			default: begin
				s_d.phase = FBC_IDLE;
			end
		endcase

		// unmapped words answer with zero, writes dropped
		if (take) begin
			s_d.rdata = fbc_pkg::UNMAPPED_VAL;
		end

		// tap one, outer
		if (wr_sel[0]) begin
			s_d.coeff[0] = merge(s_q.coeff[0], AVS_WRITEDATA,
				AVS_BYTEENABLE, 1'b0);
		end
		if (rd_sel[0]) begin
			s_d.rdata = read_word(s_q.coeff[0]);
		end

		// tap two, outer
		if (wr_sel[1]) begin
			s_d.coeff[1] = merge(s_q.coeff[1], AVS_WRITEDATA,
				AVS_BYTEENABLE, 1'b0);
		end
		if (rd_sel[1]) begin
			s_d.rdata = read_word(s_q.coeff[1]);
		end

		// tap three, outer
		if (wr_sel[2]) begin
			s_d.coeff[2] = merge(s_q.coeff[2], AVS_WRITEDATA,
				AVS_BYTEENABLE, 1'b0);
		end
		if (rd_sel[2]) begin
			s_d.rdata = read_word(s_q.coeff[2]);
		end

		// tap four, outer
		if (wr_sel[3]) begin
			s_d.coeff[3] = merge(s_q.coeff[3], AVS_WRITEDATA,
				AVS_BYTEENABLE, 1'b0);
		end
		if (rd_sel[3]) begin
			s_d.rdata = read_word(s_q.coeff[3]);
		end

		// tap five, centre
		if (wr_sel[fbc_pkg::CENTER_IDX]) begin
			s_d.coeff[fbc_pkg::CENTER_IDX] = merge(
				s_q.coeff[fbc_pkg::CENTER_IDX], AVS_WRITEDATA,
				AVS_BYTEENABLE, 1'b1);
		end
		if (rd_sel[fbc_pkg::CENTER_IDX]) begin
			s_d.rdata = read_word(s_q.coeff[fbc_pkg::CENTER_IDX]);
		end

		// mode word, bit zero selects dual-channel operation
		if (take && bus.mode_hit) begin
			if (AVS_WRITE) begin
				s_d.dual = next_mode(s_q.dual, AVS_WRITEDATA,
					AVS_BYTEENABLE);
			end
			s_d.rdata = mode_word(s_q.dual);
		end

		// stored fields as seen by the filter datapath
		s_d.side_out[0] = side_field(s_d.coeff[0]);
		s_d.side_out[1] = side_field(s_d.coeff[1]);
		s_d.side_out[2] = side_field(s_d.coeff[2]);
		s_d.side_out[3] = side_field(s_d.coeff[3]);
		s_d.center_out  = center_field(
			s_d.coeff[fbc_pkg::CENTER_IDX]);

		// channel-B bank flagged active to the filter only in dual-channel mode; tap values are driven in both modes
		s_d.active   = s_d.dual;
		s_d.mode_out = s_d.dual;
		s_d.waitreq  = (s_d.phase != FBC_ANSWER);

		// synchronous reset clears the whole bank
		if (RST) begin
			s_d.coeff[0]   = fbc_pkg::COEFF_RESET;
			s_d.coeff[1]   = fbc_pkg::COEFF_RESET;
			s_d.coeff[2]   = fbc_pkg::COEFF_RESET;
			s_d.coeff[3]   = fbc_pkg::COEFF_RESET;
			s_d.coeff[4]   = fbc_pkg::COEFF_RESET;
			s_d.dual       = 1'b0;
			s_d.phase      = FBC_IDLE;
			s_d.waitreq    = 1'b1;
			s_d.rdata      = fbc_pkg::UNMAPPED_VAL;
			s_d.side_out   = '0;
			s_d.center_out = '0;
			s_d.active     = 1'b0;
			s_d.mode_out   = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge CORE_CLK) begin
		s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops

	// bus side
	assign AVS_WAITREQUEST      = s_q.waitreq;
	assign AVS_READDATA         = s_q.rdata;

	// filter side
	assign CHAN_B_TAP1_VALUE    = $signed(s_q.side_out[0]);
	assign CHAN_B_TAP2_VALUE    = $signed(s_q.side_out[1]);
	assign CHAN_B_TAP3_VALUE    = $signed(s_q.side_out[2]);
	assign CHAN_B_TAP4_VALUE    = $signed(s_q.side_out[3]);
	assign CHAN_B_CENTER_VALUE  = $signed(s_q.center_out);
	assign CHAN_B_FILTER_ACTIVE = s_q.active;
	assign DUAL_CHANNEL_MODE    = s_q.mode_out;
endmodule : fbc_coeff_regs

// file: dv/fbc_assertions.sv
`timescale 1ns/1ps
module fbc_chk (
	// clock, reset, bus
	input wire logic        CORE_CLK, RST, AVS_READ, AVS_WRITE,
	input wire logic        AVS_WAITREQUEST,
	input wire logic [11:0] AVS_ADDRESS,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	// filter side
	input wire logic signed [11:0] CHAN_B_TAP1_VALUE, CHAN_B_TAP2_VALUE,
	input wire logic signed [11:0] CHAN_B_TAP3_VALUE, CHAN_B_TAP4_VALUE,
	input wire logic signed [17:0] CHAN_B_CENTER_VALUE,
	input wire logic        CHAN_B_FILTER_ACTIVE, DUAL_CHANNEL_MODE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	sequence wr_end(a);
		AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE == 4'hF
			&& AVS_ADDRESS == a;
	endsequence
	rst_zero_a: assert property ($past(RST) |->
		!CHAN_B_TAP1_VALUE && !CHAN_B_CENTER_VALUE && !DUAL_CHANNEL_MODE)
		else $error("value not zero after reset");
	ans_time_a: assert property ($rose(AVS_READ || AVS_WRITE) |->
		##[1:2] !AVS_WAITREQUEST) else $error("no answer");
	ans_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	tap1_wr_a: assert property (wr_end(fbc_pkg::TAP1_OFS) |->
		CHAN_B_TAP1_VALUE == AVS_WRITEDATA[11:0]) else $error("tap1");
	tap2_wr_a: assert property (wr_end(fbc_pkg::TAP2_OFS) |->
		CHAN_B_TAP2_VALUE == AVS_WRITEDATA[11:0]) else $error("tap2");
	tap3_wr_a: assert property (wr_end(fbc_pkg::TAP3_OFS) |->
		CHAN_B_TAP3_VALUE == AVS_WRITEDATA[11:0]) else $error("tap3");
	tap4_wr_a: assert property (wr_end(fbc_pkg::TAP4_OFS) |->
		CHAN_B_TAP4_VALUE == AVS_WRITEDATA[11:0]) else $error("tap4");
	center_wr_a: assert property (wr_end(fbc_pkg::CENTER_OFS) |->
		CHAN_B_CENTER_VALUE == AVS_WRITEDATA[17:0]) else $error("center");
	mode_wr_a: assert property (wr_end(fbc_pkg::MODE_OFS) |->
		DUAL_CHANNEL_MODE == AVS_WRITEDATA[0]) else $error("mode");
	bank_use_a: assert property (CHAN_B_FILTER_ACTIVE == DUAL_CHANNEL_MODE)
		else $error("filter active differs from mode");
	hold_val_a: assert property (!AVS_WRITE && !$past(AVS_WRITE) |->
		$stable(CHAN_B_CENTER_VALUE)) else $error("center moved");
endmodule : fbc_chk
bind fbc_coeff_regs fbc_chk chk (.*);

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic        CORE_CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic        CHAN_B_FILTER_ACTIVE, DUAL_CHANNEL_MODE;
	logic [11:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, d, taps[5], exp_q[$];
	logic [3:0]  AVS_BYTEENABLE;
	logic signed [11:0] CHAN_B_TAP1_VALUE, CHAN_B_TAP2_VALUE;
	logic signed [11:0] CHAN_B_TAP3_VALUE, CHAN_B_TAP4_VALUE;
	logic signed [17:0] CHAN_B_CENTER_VALUE;
	wire  [65:0] tap_all = {CHAN_B_TAP1_VALUE, CHAN_B_TAP2_VALUE,
		CHAN_B_TAP3_VALUE, CHAN_B_TAP4_VALUE, CHAN_B_CENTER_VALUE};
	int          num_errors, cmp_count;
	fbc_coeff_regs dut (.*);
	initial begin
		CORE_CLK = 0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	task automatic chk(input string s, input logic [65:0] e, g);
		cmp_count++;
		if (e !== g) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge CORE_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= v;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0 && ++n < 40);
		if (n >= 40) num_errors++;
		AVS_WRITE <= 0;
		AVS_READ <= 0;
	endtask : acc
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(0, a, 32'h0);
	endtask : rd
	// read results against the oldest note
	always @(posedge CORE_CLK) if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0)
		chk("readdata", exp_q.pop_front(), AVS_READDATA);
	task test_done;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		#100000 num_errors++;
		test_done();
	end
	initial begin
		RST = 1'b1;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = '0;
		AVS_WRITEDATA = '0;
		AVS_BYTEENABLE = 4'hF;
		d = $urandom(32'h237F);
		repeat (3) @(posedge CORE_CLK);
		RST <= 0;
		for (int i = 0; i < 6; i++) rd(fbc_pkg::TAP1_OFS + 12'(2 * i), 0);
		$display("end reset values");
		for (int i = 0; i < 5; i++) begin
			d = $urandom;
			taps[i] = d & (i == 4 ? 32'hFFFFFF : 32'hFFFF);
			acc(1, fbc_pkg::TAP1_OFS + 12'(2 * i), d);
		end
		acc(1, 12'h449, 32'hFFFFFFFF);
		rd(12'h449, 0);
		for (int i = 0; i < 5; i++) rd(fbc_pkg::TAP1_OFS + 12'(2 * i), taps[i]);
		chk("taps", {taps[0][11:0], taps[1][11:0], taps[2][11:0], taps[3][11:0], taps[4][17:0]}, tap_all);
		AVS_BYTEENABLE <= 4'h2;
		acc(1, fbc_pkg::TAP1_OFS, 32'hFFFFFFFF);
		AVS_BYTEENABLE <= 4'hF;
		rd(fbc_pkg::TAP1_OFS, {taps[0][31:16], 8'hFF, taps[0][7:0]});
		$display("end write readback");
		acc(1, fbc_pkg::MODE_OFS, 32'h1);
		chk("dual", 2'b11, {CHAN_B_FILTER_ACTIVE, DUAL_CHANNEL_MODE});
		acc(1, fbc_pkg::MODE_OFS, 32'h0);
		chk("single", 2'b00, {CHAN_B_FILTER_ACTIVE, DUAL_CHANNEL_MODE});
		$display("end mode");
		@(posedge CORE_CLK) RST <= 1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 0;
		@(posedge CORE_CLK);
		chk("taps", 0, tap_all);
		chk("notes left", 0, exp_q.size());
		$display("end second reset");
		test_done();
	end
endmodule : tb
